/* fcs_array_model.sv */
// Flash array model: clears cells of words handed over, can stall and fail.
// Assumes the sequencer clock; one page of cells, erased by the bench.
`timescale 1ns/100ps
module fcs_array_model (
	input logic			clock,
	input logic			nrst,
	input logic			slow,
	input logic [7:0]		fail_at,
	input logic			ary_valid,
	output logic			ary_ready,
	input fcs_pkg::fcs_wr_t	ary_word,
	output logic			ary_busy,
	output logic			ary_fail
);
	logic [31:0]	mem [0:127];
	logic [7:0]	bc_q;
	logic [7:0]	n_q;

	assign ary_busy = bc_q != 8'h00;
	assign ary_ready = !ary_busy;

	// Plain always: the bench erases cells directly
	always @(posedge clock) begin
		ary_fail <= 1'b0;
		if (!nrst) begin
			bc_q <= 8'h00;
			n_q <= 8'h00;
		end else if (ary_valid && ary_ready) begin
			mem[ary_word.addr[8:2]] <= mem[ary_word.addr[8:2]] & ary_word.data;
			bc_q <= slow ? 8'h28 : 8'h03;
			n_q <= n_q + 8'h01;
		end else if (ary_busy) begin
			bc_q <= bc_q - 8'h01;
			ary_fail <= bc_q == 8'h01 && n_q == fail_at;
		end
	end
endmodule

/* fcs_map.svh */
// Constants of the flash command sequencer: command cycles, page and block layout.
// Assumes command writes carry a full 32-bit address and word.
`ifndef FCS_MAP_SVH
`define FCS_MAP_SVH

// Address bits [20:8] compared in each command cycle
`define FCS_CMD_MSB    20
`define FCS_CMD_LSB    8
`define FCS_CMD_ADDR_A 13'h0055
`define FCS_CMD_ADDR_B 13'h00aa

// Data of the command cycles
`define FCS_DATA_UNLK1 32'h0000_00aa
`define FCS_DATA_UNLK2 32'h0000_0055
`define FCS_DATA_PROG  32'h0000_00a0
`define FCS_DATA_READ  32'h0000_00f0

// Page: 128 words sharing address bits [31:9]
`define FCS_PAGE_LSB   9
`define FCS_WORD_LSB   2
`define FCS_PAGE_WORDS 8'h80
`define FCS_LAST_WORD  7'h7f

// Protection blocks of 128 kB, four of them
`define FCS_BLK_MSB    18
`define FCS_BLK_LSB    17

// Reset values
`define FCS_RDY_RST    1'h1
`define FCS_CNT_RST    7'h00

`endif

/* fcs_pkg.sv */
// Types of the flash command sequencer.
// Assumes fcs_map.svh is compiled alongside.
package fcs_pkg;

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] data;
	} fcs_wr_t;

	typedef enum logic [3:0] {
		FCS_READ,
		FCS_CYC1,
		FCS_CYC2,
		FCS_ARMED,
		FCS_PROG,
		FCS_DRAIN,
		FCS_FAIL,
		FCS_FCYC1,
		FCS_FCYC2
	} fcs_state_t;

endpackage

/* fcs_seq_props.sv */
// Port checker of the flash command sequencer.
// Assumes one clock domain; bound onto fcs_sequencer from the bench top.
`timescale 1ns/100ps
module fcs_seq_props (
	input logic			clock,
	input logic			nrst,
	input logic			wr_ready,
	input logic [3:0]		blk_protect,
	input logic			ary_valid,
	input logic			ary_ready,
	input fcs_pkg::fcs_wr_t	ary_word,
	input logic			ary_fail,
	input logic			ready_busy_flag,
	input logic			read_mode,
	input logic			ary_read_en,
	input logic			prog_done
);
	logic		have_q;
	logic [22:0]	pg_q;

	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);

	// Page of the latest word handed over; have_q cleared while ready/busy is 1
	always_ff @(posedge clock) begin
		if (!nrst || ready_busy_flag)
			have_q <= 1'b0;
		else if (ary_valid && ary_ready)
			have_q <= 1'b1;
	end
	always_ff @(posedge clock) begin
		if (ary_valid && ary_ready)
			pg_q <= ary_word.addr[31:9];
	end

	AST_RST_READ: assert property ($rose(nrst) |-> ready_busy_flag && read_mode && !ary_valid)
		else $error("not in read mode after reset");
	AST_RD_EN: assert property (ary_read_en == ready_busy_flag)
		else $error("read enable differs from ready flag");
	AST_VALID_BUSY: assert property (ary_valid |-> !ready_busy_flag && !read_mode)
		else $error("array word offered while ready");
	AST_DONE: assert property (prog_done |-> ready_busy_flag && read_mode && !$past(ready_busy_flag))
		else $error("done without return to read mode");
	AST_PROT: assert property (ary_valid |-> !blk_protect[ary_word.addr[18:17]])
		else $error("word sent into protected block");
	AST_PAGE: assert property (ary_valid && have_q |-> ary_word.addr[31:9] == pg_q && ary_word.addr[1:0] == 2'h0)
		else $error("word outside the page");
	AST_HOLD: assert property (ary_valid && !ary_ready && !ary_fail |=> ary_valid && $stable(ary_word))
		else $error("array word dropped while stalled");
	AST_FAIL: assert property (ary_fail |=> !ready_busy_flag && !prog_done)
		else $error("left lock after failure");

	cover property (prog_done);
	cover property (ary_fail);
	cover property (!wr_ready);
endmodule

/* fcs_sequencer.sv */
// Flash command sequencer: decodes store-word writes, runs page program.
// Assumes bus writes and the array port sit on the same clock as the sequencer.
//
// Summary of operation
// R1: A complete three-cycle read/reset sequence returns to read mode after its third cycle.
// R2: Any write deviating from the command sequence abandons it and falls back to read mode.
// R3: Host cancels partial or wrong commands with read/reset; sequencer then re-enters read mode.
// R4: Host drives address bits [31:21] equal to the command region's virtual address.
// R5: Host spaces command writes at least 15 system clocks apart.
// R6: No flash reads, DMA, jumps or maskable interrupts during a command sequence.
// R7: Host checks ready/busy flag is 1 before a command's first write.
// R8: CPU reset aborts any automatic operation and returns to read mode.
// R9: Programming only clears cells from 1 to 0; only erase sets them.
// R10: A page is 128 words sharing address bits [31:9], offsets 0 to 0x1FF.
// R11: Programming starts at the fourth write with page top; later writes give next words.
// R12: New command sequences are ignored while page programming runs; only reset interrupts.
// R13: A successful page sets ready/busy to 1 and returns to read mode by itself.
// R14: One command programs exactly one page; data never crosses a page boundary.
// R15: No cell in a protected block is altered.
// R16: A failed program locks the sequencer until read/reset command or hardware reset.
// R17: From the fourth write of page program, software read/reset has no effect.
// R18: Host programs each erased page once; erase before programming again.
// R19: Host writes the whole page, all-ones for words left unprogrammed.
// R20: No internal verify; host reads back programmed data.
// R21: After reset interrupts programming, host erases the page before reprogramming.
// R22: Host follows each command store with a synchronising barrier.
// R23: Ready/busy reads 0 during automatic operation, 1 when it terminates.
// R24: Writing 0xF0 to any flash address is the read command.
// R25: Array read data is undefined while ready/busy is 0.
// R26: Busy holds from operation start until it ends or reset aborts it.
`timescale 1ns/100ps
`include "fcs_map.svh"

module fcs_sequencer (
	input  wire logic           clock,
	input  wire logic           nrst,
	input  wire logic           wr_valid,
	output logic                wr_ready,
	input  wire fcs_pkg::fcs_wr_t wr_req,
	input  wire logic [3:0]     blk_protect,
	output logic                ary_valid,
	input  wire logic           ary_ready,
	output fcs_pkg::fcs_wr_t    ary_word,
	input  wire logic           ary_busy,
	input  wire logic           ary_fail,
	output logic                ready_busy_flag,
	output logic                read_mode,
	output logic                ary_read_en,
	output logic                seq_abort,
	output logic                prog_done
);

	// Matches one command cycle on address bits [20:8] and data
	function automatic logic cmd_hit(
		input logic [31:0] addr,
		input logic [31:0] data,
		input logic [12:0] a,
		input logic [31:0] d
	);
		cmd_hit = (addr[`FCS_CMD_MSB:`FCS_CMD_LSB] == a) && (data == d);
	endfunction

	function automatic logic is_busy(input fcs_pkg::fcs_state_t s);
		is_busy = (s == fcs_pkg::FCS_PROG) || (s == fcs_pkg::FCS_DRAIN) ||
			(s == fcs_pkg::FCS_FAIL) || (s == fcs_pkg::FCS_FCYC1) || (s == fcs_pkg::FCS_FCYC2);
	endfunction

	// Protection bit of the block holding this address
	function automatic logic blk_locked(input logic [31:0] addr, input logic [3:0] prot);
		blk_locked = prot[addr[`FCS_BLK_MSB:`FCS_BLK_LSB]];
	endfunction

	fcs_pkg::fcs_state_t state_q;
	fcs_pkg::fcs_state_t state_d;
	fcs_pkg::fcs_wr_t    buf0_q;
	fcs_pkg::fcs_wr_t    buf1_q;
	fcs_pkg::fcs_wr_t    push_word;
	logic                buf0_v_q;
	logic                buf1_v_q;
	logic                buf0_v_d;
	logic                buf1_v_d;
	logic                wr_ready_q;
	logic                take;
	logic                push;
	logic                pop;
	logic                flush;
	logic [22:0]         page_q;
	logic [6:0]          word_q;
	logic                prot_q;
	logic                idle_q;
	logic                idle_now;
	logic                rdy_q;
	logic                read_mode_q;
	logic                rd_en_q;
	logic                abort_d;
	logic                abort_q;
	logic                done_d;
	logic                done_q;
	logic                unlk1;
	logic                unlk2;
	logic                rd_cmd;
	logic                prog_cmd;
	logic                single_rd;

	assign take      = wr_valid && wr_ready_q;
	assign unlk1     = cmd_hit(wr_req.addr, wr_req.data, `FCS_CMD_ADDR_A, `FCS_DATA_UNLK1);
	assign unlk2     = cmd_hit(wr_req.addr, wr_req.data, `FCS_CMD_ADDR_B, `FCS_DATA_UNLK2);
	assign rd_cmd    = cmd_hit(wr_req.addr, wr_req.data, `FCS_CMD_ADDR_A, `FCS_DATA_READ);
	assign prog_cmd  = cmd_hit(wr_req.addr, wr_req.data, `FCS_CMD_ADDR_A, `FCS_DATA_PROG);
	assign single_rd = (wr_req.data == `FCS_DATA_READ);
	assign idle_now  = !buf0_v_q && !buf1_v_q && !ary_busy;

	// Sequence decoder
	always_comb begin
		state_d = state_q;
		abort_d = 1'b0;
		done_d  = 1'b0;
		unique case (state_q)
			fcs_pkg::FCS_READ: begin
				// Single 0xF0 write is the read command: already in read mode
				if (take && unlk1) begin
					state_d = fcs_pkg::FCS_CYC1;
				end else if (take && !single_rd) begin
					abort_d = 1'b1; // R2
				end
			end
			fcs_pkg::FCS_CYC1: begin
				if (take) begin
					if (unlk2) begin
						state_d = fcs_pkg::FCS_CYC2;
					end else begin
						state_d = fcs_pkg::FCS_READ; // R2 R3 R24
						abort_d = !single_rd;
					end
				end
			end
			fcs_pkg::FCS_CYC2: begin
				if (take) begin
					if (prog_cmd) begin
						state_d = fcs_pkg::FCS_ARMED;
					end else begin
						state_d = fcs_pkg::FCS_READ; // R1 R2 R3 R24
						abort_d = !rd_cmd && !single_rd;
					end
				end
			end
			fcs_pkg::FCS_ARMED: begin
				// Fourth write is page data, whatever its value
				if (take) begin
					state_d = fcs_pkg::FCS_PROG; // R11 R17
				end
			end
			fcs_pkg::FCS_PROG: begin
				// Command patterns here are plain page data
				if (ary_fail) begin
					state_d = fcs_pkg::FCS_FAIL; // R16
				end else if (take && word_q == `FCS_LAST_WORD) begin
					state_d = fcs_pkg::FCS_DRAIN; // R12 R17
				end
			end
			fcs_pkg::FCS_DRAIN: begin
				if (ary_fail) begin
					state_d = fcs_pkg::FCS_FAIL; // R16
				end else if (idle_q && idle_now) begin
					state_d = fcs_pkg::FCS_READ; // R13
					done_d  = 1'b1;
				end
			end
			fcs_pkg::FCS_FAIL: begin
				// Locked: only the read/reset command leaves
				if (take && unlk1) begin
					state_d = fcs_pkg::FCS_FCYC1;
				end else if (take && single_rd) begin
					state_d = fcs_pkg::FCS_READ; // R16 R24
				end
			end
			fcs_pkg::FCS_FCYC1: begin
				if (take) begin
					state_d = unlk2 ? fcs_pkg::FCS_FCYC2 :
						(single_rd ? fcs_pkg::FCS_READ : fcs_pkg::FCS_FAIL); // R16
				end
			end
			fcs_pkg::FCS_FCYC2: begin
				if (take) begin
					state_d = (rd_cmd || single_rd) ? fcs_pkg::FCS_READ : fcs_pkg::FCS_FAIL; // R1 R16
				end
			end
			default: begin
				state_d = fcs_pkg::FCS_READ;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			state_q <= fcs_pkg::FCS_READ; // R8
		end else begin
			state_q <= state_d;
		end
	end

	// Page base, word index and protection, latched at the fourth write
	always_ff @(posedge clock) begin
		if (!nrst) begin
			page_q <= 23'h000000;
			word_q <= `FCS_CNT_RST;
			prot_q <= 1'b0;
		end else if (state_q == fcs_pkg::FCS_ARMED && take) begin
			page_q <= wr_req.addr[31:`FCS_PAGE_LSB]; // R10
			word_q <= 7'h01;
			prot_q <= blk_locked(wr_req.addr, blk_protect); // R15
		end else if (state_q == fcs_pkg::FCS_PROG && take) begin
			word_q <= word_q + 7'h01; // R11
		end
	end

	// Address is built from the page, so words never leave it
	always_comb begin
		push_word.data = wr_req.data; // R9
		if (state_q == fcs_pkg::FCS_ARMED) begin
			push_word.addr = {wr_req.addr[31:`FCS_PAGE_LSB], 9'h000}; // R10 R11
		end else begin
			push_word.addr = {page_q, word_q, 2'h0}; // R14
		end
	end

	// Protected pages swallow their words without reaching the array
	assign push = take && !flush &&
		((state_q == fcs_pkg::FCS_ARMED && !blk_locked(wr_req.addr, blk_protect)) ||
		(state_q == fcs_pkg::FCS_PROG && !prot_q)); // R15
	assign pop   = buf0_v_q && ary_ready;
	assign flush = ary_fail;

	// Two-entry buffer; head always sits in buf0 so the array port is a flop
	always_comb begin
		buf0_v_d = buf0_v_q;
		buf1_v_d = buf1_v_q;
		if (flush) begin
			buf0_v_d = 1'b0;
			buf1_v_d = 1'b0;
		end else if (pop) begin
			buf0_v_d = buf1_v_q || push;
			buf1_v_d = buf1_v_q && push;
		end else if (push) begin
			buf0_v_d = 1'b1;
			buf1_v_d = buf0_v_q;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			buf0_v_q <= 1'b0;
			buf1_v_q <= 1'b0;
		end else begin
			buf0_v_q <= buf0_v_d;
			buf1_v_q <= buf1_v_d;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			buf0_q <= '0;
			buf1_q <= '0;
		end else if (pop) begin
			buf0_q <= buf1_v_q ? buf1_q : push_word;
			if (buf1_v_q && push) begin
				buf1_q <= push_word;
			end
		end else if (push) begin
			if (buf0_v_q) begin
				buf1_q <= push_word;
			end else begin
				buf0_q <= push_word;
			end
		end
	end

	// Ready drops once the buffer fills, stalling the writer without loss
	always_ff @(posedge clock) begin
		if (!nrst) begin
			wr_ready_q <= 1'b1;
		end else begin
			wr_ready_q <= !buf1_v_d;
		end
	end

	// Drain needs two idle samples, since array busy lags its acceptance
	always_ff @(posedge clock) begin
		if (!nrst) begin
			idle_q <= 1'b0;
		end else begin
			idle_q <= idle_now;
		end
	end

	// Status follows the next state, so busy rises with the fourth write
	always_ff @(posedge clock) begin
		if (!nrst) begin
			rdy_q <= `FCS_RDY_RST; // R8
		end else begin
			rdy_q <= !is_busy(state_d); // R23 R26 R13
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			read_mode_q <= 1'b1;
		end else begin
			read_mode_q <= (state_d == fcs_pkg::FCS_READ);
		end
	end

	// Array read data is not trusted while busy
	always_ff @(posedge clock) begin
		if (!nrst) begin
			rd_en_q <= 1'b1;
		end else begin
			rd_en_q <= !is_busy(state_d); // R25
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			abort_q <= 1'b0;
		end else begin
			abort_q <= abort_d;
		end
	end

	// Done only means no failure was reported; nothing is read back
	always_ff @(posedge clock) begin
		if (!nrst) begin
			done_q <= 1'b0;
		end else begin
			done_q <= done_d; // R20
		end
	end

	assign wr_ready        = wr_ready_q;
	assign ary_valid       = buf0_v_q;
	assign ary_word        = buf0_q;
	assign ready_busy_flag = rdy_q;
	assign read_mode       = read_mode_q;
	assign ary_read_en     = rd_en_q;
	assign seq_abort       = abort_q;
	assign prog_done       = done_q;

endmodule

/* tb_fcs_sequencer.sv */
// Bench of the flash command sequencer with an array model.
// Assumes inputs driven at the falling edge, 15-cycle write spacing.
`timescale 1ns/100ps
module tb_fcs_sequencer;
	logic			clock, nrst, wr_valid, wr_ready, ary_valid, ary_ready, ary_busy, ary_fail;
	logic			ready_busy_flag, read_mode, ary_read_en, seq_abort, prog_done;
	logic			slow, s_ab, s_rb, full, done;
	logic [3:0]		blk_protect;
	logic [7:0]		fail_at;
	fcs_pkg::fcs_wr_t	wr_req, ary_word;
	int			err_count, n_tests;
	localparam logic [31:0]	CA = 32'h0000_5500;
	localparam logic [31:0]	CB = 32'h0000_aa00;

	fcs_sequencer uut (.clock(clock), .nrst(nrst), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_req(wr_req),
		.blk_protect(blk_protect), .ary_valid(ary_valid), .ary_ready(ary_ready), .ary_word(ary_word),
		.ary_busy(ary_busy), .ary_fail(ary_fail), .ready_busy_flag(ready_busy_flag), .read_mode(read_mode),
		.ary_read_en(ary_read_en), .seq_abort(seq_abort), .prog_done(prog_done));
	fcs_array_model pa (.clock(clock), .nrst(nrst), .slow(slow), .fail_at(fail_at), .ary_valid(ary_valid),
		.ary_ready(ary_ready), .ary_word(ary_word), .ary_busy(ary_busy), .ary_fail(ary_fail));

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	task report_and_stop;
		$display("checks %0d errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask

	function logic [31:0] dat(input int n, input logic f);
		return (n == 5 && !f) ? 32'h0000_00f0 : 32'h5a5a_0000 | 32'(n);
	endfunction

	task wt;
		@(negedge clock);
		if (prog_done === 1'b1)
			done = 1'b1;
	endtask

	task wr(input logic [31:0] a, input logic [31:0] dt);
		int i;
		wr_req = {a, dt};
		wr_valid = 1'b1;
		// Ready is looked at off the edge, where it has settled
		for (i = 0; i < 300; i++) begin
			if (wr_ready === 1'b1)
				break;
			full = 1'b1;
			@(negedge clock);
		end
		if (i == 300) begin
			chk("wr_ready", 1, wr_ready);
			report_and_stop;
		end
		@(posedge clock);
		@(negedge clock);
		wr_valid = 1'b0;
		wr_req = ~wr_req;
		s_ab = seq_abort;
		s_rb = ready_busy_flag;
		if (prog_done === 1'b1)
			done = 1'b1;
		repeat (15) wt;
	endtask

	task do_reset;
		nrst = 1'b0;
		repeat (20) @(negedge clock);
		nrst = 1'b1;
		@(negedge clock);
	endtask

	task t_abort;
		wr(CA, 32'h0000_00aa);
		wr(CA, 32'h0000_0055);
		chk("abort", 1, s_ab);
		chk("mode", 1, read_mode);
		wr(CA, 32'h0000_00aa);
		wr(CB, 32'h0000_0055);
		wr(CA, 32'h0000_00f0);
		chk("abort", 0, s_ab);
		chk("ready", 1, s_rb);
		wr(CA, 32'h0000_00aa);
		wr(CB, 32'h0000_0055);
		wr(CB, 32'h0000_00f0);
		chk("abort", 0, s_ab);
		chk("mode", 1, read_mode);
	endtask

	task t_prog(input logic [31:0] p, input logic [3:0] prot, input logic f);
		int n;
		do_reset;
		blk_protect = prot;
		fail_at = f ? 8'h04 : 8'hff;
		done = 1'b0;
		for (n = 0; n < 128; n++) pa.mem[n] = '1;
		chk("ready", 1, ready_busy_flag);
		wr(CA, 32'h0000_00aa);
		wr(CB, 32'h0000_0055);
		wr(CA, 32'h0000_00a0);
		for (n = 0; n < 128; n++) begin
			wr(p | 32'(n << 2), dat(n, f));
			if (n == 0 || n == 5) begin
				chk("busy", 0, s_rb);
				chk("rd_en", 0, ary_read_en);
			end
		end
		for (n = 0; n < 600 && !done; n++) wt;
		chk("done", !f, done);
		chk("ready", !f, ready_busy_flag);
		if (!f)
			for (n = 0; n < 128; n++) chk("cell", prot[p[18:17]] ? 32'hffff_ffff : dat(n, f), pa.mem[n]);
		if (f && p[11]) begin
			// Lock survives a wrong write, leaves on the full read/reset sequence
			wr(CA, 32'h0000_00aa);
			wr(CA, 32'h0000_0055);
			chk("busy", 0, s_rb);
			wr(CA, 32'h0000_00aa);
			wr(CB, 32'h0000_0055);
			wr(CA, 32'h0000_00f0);
			chk("ready", 1, s_rb);
		end else if (f) begin
			wr(CA, 32'h0000_00f0);
			chk("ready", 1, s_rb);
		end
	endtask

	task t_hwrst;
		slow = 1'b1;
		wr(CA, 32'h0000_00aa);
		wr(CB, 32'h0000_0055);
		wr(CA, 32'h0000_00a0);
		wr(32'h0000_0400, 32'h0000_0000);
		chk("busy", 0, s_rb);
		wr(32'h0000_0404, 32'h0000_0000);
		do_reset;
		chk("ready", 1, ready_busy_flag);
		chk("mode", 1, read_mode);
		chk("ary_valid", 0, ary_valid);
		chk("wr_ready", 1, wr_ready);
		chk("rd_en", 1, ary_read_en);
	endtask

	initial begin
		{nrst, wr_valid, slow, full, done, s_ab, s_rb} = 7'h00;
		wr_req = '0;
		blk_protect = 4'h0;
		fail_at = 8'hff;
		err_count = 0;
		n_tests = 0;
		do_reset;
		t_abort;
		t_prog(32'h0000_0200, 4'h2, 1'b0);
		t_prog(32'h0002_0200, 4'h2, 1'b0);
		slow = 1'b1;
		t_prog(32'h0004_0400, 4'h0, 1'b0);
		chk("full", 1, full);
		slow = 1'b0;
		t_prog(32'h0000_0600, 4'h0, 1'b1);
		t_prog(32'h0000_0800, 4'h0, 1'b1);
		t_hwrst;
		report_and_stop;
	end
endmodule

bind fcs_sequencer fcs_seq_props chk_i (.clock(clock), .nrst(nrst), .wr_ready(wr_ready), .blk_protect(blk_protect),
	.ary_valid(ary_valid), .ary_ready(ary_ready), .ary_word(ary_word), .ary_fail(ary_fail),
	.ready_busy_flag(ready_busy_flag), .read_mode(read_mode), .ary_read_en(ary_read_en), .prog_done(prog_done));
